//--- rtl/sdms_defs.vh
// Purpose: constants for the step/dir microstep sequencer
// Assumes: 50 MHz system clock
// Notes:   resolution code 0 = 256x (width 1) ... 8 = fullstep (width 256)
`ifndef SDMS_DEFS_VH
`define SDMS_DEFS_VH

// ----------------------------------------
// Table and counter
// ----------------------------------------
`define SDMS_TABLE_BITS      10
`define SDMS_TABLE_SIZE      1024
`define SDMS_MSCNT_RST       10'h000
`define SDMS_RES_BITS        4
`define SDMS_RES_FULL        4'h8
`define SDMS_RES_RST         4'h0
`define SDMS_FULL_FIRST      10'h080
`define SDMS_HALF_FIRST      10'h040
`define SDMS_QUARTER_FIRST   10'h020

// ----------------------------------------
// Interpolator timing
// ----------------------------------------
`define SDMS_PERIOD_BITS     20
`define SDMS_PERIOD_MAX      20'hfffff
`define SDMS_SUB_STEPS       256

`endif

//--- rtl/sdms_edge_sync.v
// Purpose: synchronise step and direction, detect active step edges
// Assumes: inputs treated as asynchronous to clk_sys; two flops guard metastability
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module sdms_edge_sync
(
	// Clock and reset
	input  wire clk_sys,
	input  wire sys_rst,
	// Pins and mode
	input  wire step_in,
	input  wire dir_in,
	input  wire double_edge,
	// Synchronised results
	output reg  dir_sync_r,
	output reg  step_evt_r
);

	reg step_s1_r;
	reg step_s2_r;
	reg step_s3_r;
	reg dir_s1_r;

	// ----------------------------------------
	// Two-flop synchronisers and edge history
	// ----------------------------------------
	// R2 sample and synchronise
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			step_s1_r  <= 1'b0;
			step_s2_r  <= 1'b0;
			step_s3_r  <= 1'b0;
			dir_s1_r   <= 1'b0;
			dir_sync_r <= 1'b0;
		end
		else
		begin
			step_s1_r  <= step_in;
			step_s2_r  <= step_s1_r;
			step_s3_r  <= step_s2_r;
			dir_s1_r   <= dir_in;
			dir_sync_r <= dir_s1_r;
		end
	end

	// Active edge pulse, one cycle wide
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			step_evt_r <= 1'b0;
		else
		begin
			// R1 edge selection
			if (double_edge)
				step_evt_r <= step_s2_r ^ step_s3_r;
			else
				step_evt_r <= step_s2_r & ~step_s3_r;
		end
	end

endmodule

//--- rtl/sdms_period_timer.v
// Purpose: measure step period, pace sub-steps, flag standstill
// Assumes: step_evt is a one-cycle pulse per active edge
// Notes:   interval = period / 256, floored to at least one cycle
`timescale 1ns/100ps
`include "sdms_defs.vh"
module sdms_period_timer
#(
	parameter PERIOD_BITS = `SDMS_PERIOD_BITS
)
(
	// Clock and reset
	input  wire                   clk_sys,
	input  wire                   sys_rst,
	// Step events
	input  wire                   step_evt,
	// Pacing and status
	output reg                    tick_r,
	output reg                    standstill_r
);

	reg [PERIOD_BITS-1:0] elapsed_r;
	reg [PERIOD_BITS-9:0] interval_r;
	reg [PERIOD_BITS-9:0] pace_r;
	wire                  at_limit;

	assign at_limit = &elapsed_r;

	// ----------------------------------------
	// Period measurement and standstill
	// ----------------------------------------
	// Counter saturates so a long pause cannot wrap into a short period
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			elapsed_r    <= {PERIOD_BITS{1'b0}};
			interval_r   <= {(PERIOD_BITS-8){1'b1}};
			standstill_r <= 1'b0;
		end
		else if (step_evt)
		begin
			// R13 period split by 256
			elapsed_r    <= {PERIOD_BITS{1'b0}};
			interval_r   <= (elapsed_r[PERIOD_BITS-1:8] == {(PERIOD_BITS-8){1'b0}}) ?
				{{(PERIOD_BITS-9){1'b0}}, 1'b1} : elapsed_r[PERIOD_BITS-1:8];
			// R16 edge clears standstill
			standstill_r <= 1'b0;
		end
		else
		begin
			if (!at_limit)
				elapsed_r <= elapsed_r + {{(PERIOD_BITS-1){1'b0}}, 1'b1};
			// R14 timeout sets standstill
			if (at_limit)
				standstill_r <= 1'b1;
		end
	end

	// Sub-step pacing, restarted on every edge
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pace_r <= {(PERIOD_BITS-8){1'b0}};
			tick_r <= 1'b0;
		end
		else if (step_evt)
		begin
			pace_r <= {(PERIOD_BITS-8){1'b0}};
			tick_r <= 1'b0;
		end
		else if (pace_r + {{(PERIOD_BITS-9){1'b0}}, 1'b1} >= interval_r)
		begin
			pace_r <= {(PERIOD_BITS-8){1'b0}};
			tick_r <= 1'b1;
		end
		else
		begin
			pace_r <= pace_r + {{(PERIOD_BITS-9){1'b0}}, 1'b1};
			tick_r <= 1'b0;
		end
	end

endmodule

//--- rtl/sdms_sequencer.v
// Function
// R1 - Double-edge set: both step edges active; otherwise rising only.
// R2 - Step and direction are synchronised before edge detection.
// R3 - Controller keeps step rate within half or quarter clock.
// R4 - 1024-entry table spans four full steps; counter indexes it.
// R5 - Active edge moves counter by width; up when dir low.
// R6 - Width is 1 at finest resolution up to 256 at fullstep.
// R7 - Coarser resolution snaps counter to nearest valid position.
// R8 - Fullstep visits 128, 384, 640, 896 only.
// R9 - Half step positions start at 64, spaced 128.
// R10 - Quarter step starts at 32, spaced 64; odd multiples of half width.
// R11 - Interpolation issues single-entry microsteps, 2 to 256 per edge.
// R12 - Interpolation only when enable bit set; else whole width at once.
// R13 - Previous period measured, split into up to 256 intervals.
// R14 - No edge within maximum period sets standstill.
// R15 - Standstill selects hold current scale instead of run.
// R16 - Next active edge clears standstill.
// R17 - New rate adopted after one period; unissued microsteps skipped.
// R18 - Controller avoids double-edge with interpolation unless duty 50%.
// R19 - Counter is ten bits and wraps modulo 1024.
// R20 - Resolution code 0..8 selects width 1..256.
//
// Purpose: step/dir front end and microstep counter of a stepper driver
// Assumes: single clock clk_sys at 50 MHz, async active-high reset
// Notes:   configuration bits are plain ports; outputs come from flops
`timescale 1ns/100ps
`include "sdms_defs.vh"
module sdms_sequencer
#(
	parameter TABLE_BITS  = `SDMS_TABLE_BITS,
	parameter PERIOD_BITS = `SDMS_PERIOD_BITS,
	parameter CUR_BITS    = 5
)
(
	// Clock and reset
	input  wire                   clk_sys,
	input  wire                   sys_rst,
	// Step and direction pins
	input  wire                   step_in,
	input  wire                   dir_in,
	// Chopper configuration bits
	input  wire                   double_edge,
	input  wire                   interp_en,
	input  wire [`SDMS_RES_BITS-1:0] resolution,
	// Current scales
	input  wire [CUR_BITS-1:0]    run_current_scale,
	input  wire [CUR_BITS-1:0]    hold_current_scale,
	// Status and position
	output reg  [TABLE_BITS-1:0]  mscnt_r,
	output reg                    standstill_r,
	output reg  [CUR_BITS-1:0]    current_scale_r,
	output reg                    microstep_r
);

	// ----------------------------------------
	// Interpolator states, one-hot
	// ----------------------------------------
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_RUN  = 2'b10;

	wire                  dir_sync;
	wire                  step_evt;
	wire                  tick;
	wire                  stand;
	reg  [1:0]            state_r;
	reg  [1:0]            state_nxt;
	reg  [8:0]            remain_r;
	reg  [8:0]            remain_nxt;
	reg                   run_dir_r;
	reg                   run_dir_nxt;
	reg  [TABLE_BITS-1:0] mscnt_nxt;
	reg  [`SDMS_RES_BITS-1:0] res_r;
	reg  [TABLE_BITS-1:0] width;
	reg  [TABLE_BITS-1:0] half_w;
	reg  [TABLE_BITS-1:0] mask;
	reg  [TABLE_BITS-1:0] snapped;
	reg                   coarser;
	reg  [`SDMS_RES_BITS-1:0] res_eff;

	// ----------------------------------------
	// Input front end and period timer
	// ----------------------------------------
	// R2 synchronised step path
	sdms_edge_sync u_sync
	(
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.step_in     (step_in),
		.dir_in      (dir_in),
		.double_edge (double_edge),
		.dir_sync_r  (dir_sync),
		.step_evt_r  (step_evt)
	);

	sdms_period_timer #(.PERIOD_BITS(PERIOD_BITS)) u_timer
	(
		.clk_sys      (clk_sys),
		.sys_rst      (sys_rst),
		.step_evt     (step_evt),
		.tick_r       (tick),
		.standstill_r (stand)
	);

	// ----------------------------------------
	// Step width and snap position
	// ----------------------------------------
	// Codes above fullstep are clamped to fullstep
	always @*
	begin
		res_eff = (resolution > `SDMS_RES_FULL) ? `SDMS_RES_FULL : resolution;
		// R6 width from resolution
		// R20 code 0..8
		width   = {{(TABLE_BITS-1){1'b0}}, 1'b1} << res_eff;
		half_w  = width >> 1;
		mask    = ~(width - {{(TABLE_BITS-1){1'b0}}, 1'b1});
		// R7 nearest valid position
		// R10 odd multiple of half width
		// R8 fullstep lands on 128 + k*256
		// R9 half step lands on 64 + k*128
		snapped = (mscnt_r & mask) | half_w;
		coarser = (res_eff > res_r) && (res_eff != 4'h0);
	end

	// ----------------------------------------
	// Counter and interpolator next state
	// ----------------------------------------
	always @*
	begin
		state_nxt   = state_r;
		remain_nxt  = remain_r;
		run_dir_nxt = run_dir_r;
		mscnt_nxt   = mscnt_r;
		case (state_r)
			ST_IDLE:
			begin
				if (step_evt && interp_en)
				begin
					// R11 first single-entry microstep now
					mscnt_nxt   = dir_sync ? mscnt_r - {{(TABLE_BITS-1){1'b0}}, 1'b1}
						: mscnt_r + {{(TABLE_BITS-1){1'b0}}, 1'b1};
					remain_nxt  = width[8:0] - 9'h001;
					run_dir_nxt = dir_sync;
					if (width[8:0] != 9'h001)
						state_nxt = ST_RUN;
				end
				else if (step_evt)
				begin
					// R12 whole width at once
					// R5 up when dir low
					// R19 wraps modulo 1024
					mscnt_nxt = dir_sync ? mscnt_r - width : mscnt_r + width;
				end
				else if (coarser)
					mscnt_nxt = snapped;
			end
			ST_RUN:
			begin
				if (step_evt)
				begin
					// R17 unissued microsteps skipped to target
					mscnt_nxt   = (run_dir_r ? mscnt_r - {1'b0, remain_r}
						: mscnt_r + {1'b0, remain_r});
					mscnt_nxt   = dir_sync ? mscnt_nxt - {{(TABLE_BITS-1){1'b0}}, 1'b1}
						: mscnt_nxt + {{(TABLE_BITS-1){1'b0}}, 1'b1};
					remain_nxt  = width[8:0] - 9'h001;
					run_dir_nxt = dir_sync;
					if (width[8:0] == 9'h001 || !interp_en)
					begin
						mscnt_nxt = dir_sync ? mscnt_nxt - (width - {{(TABLE_BITS-1){1'b0}}, 1'b1})
							: mscnt_nxt + (width - {{(TABLE_BITS-1){1'b0}}, 1'b1});
						state_nxt = ST_IDLE;
					end
				end
				else if (tick && !stand)
				begin
					// R13 paced by measured interval
					mscnt_nxt  = run_dir_r ? mscnt_r - {{(TABLE_BITS-1){1'b0}}, 1'b1}
						: mscnt_r + {{(TABLE_BITS-1){1'b0}}, 1'b1};
					remain_nxt = remain_r - 9'h001;
					if (remain_r == 9'h001)
						state_nxt = ST_IDLE;
				end
				else if (stand)
				begin
					// Long pause: finish the step so position stays on grid
					mscnt_nxt = run_dir_r ? mscnt_r - {1'b0, remain_r}
						: mscnt_r + {1'b0, remain_r};
					remain_nxt = 9'h000;
					state_nxt  = ST_IDLE;
				end
			end
			default:
			begin
				state_nxt  = ST_IDLE;
				remain_nxt = 9'h000;
			end
		endcase
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	// R4 counter indexes the 1024-entry table
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r     <= ST_IDLE;
			remain_r    <= 9'h000;
			run_dir_r   <= 1'b0;
			mscnt_r     <= `SDMS_MSCNT_RST;
			res_r       <= `SDMS_RES_RST;
			microstep_r <= 1'b0;
		end
		else
		begin
			state_r     <= state_nxt;
			remain_r    <= remain_nxt;
			run_dir_r   <= run_dir_nxt;
			mscnt_r     <= mscnt_nxt;
			// Stored code moves only on idle cycles without a step edge;
			// updating it on a step or on the last sub-step would lose the snap
			if (state_r == ST_IDLE && !step_evt)
				res_r <= res_eff;
			microstep_r <= (mscnt_nxt != mscnt_r);
		end
	end

	// Status and current scale
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			standstill_r    <= 1'b0;
			current_scale_r <= {CUR_BITS{1'b0}};
		end
		else
		begin
			// R14 standstill reported
			// R16 cleared via timer on edge
			standstill_r    <= stand;
			// R15 hold current in standstill
			current_scale_r <= stand ? hold_current_scale : run_current_scale;
		end
	end

endmodule

//--- bench/sdms_seq_asserts.sv
// Purpose: port-level checks on the microstep sequencer
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   idle counter starts saturated so reset needs no special case
`timescale 1ns/100ps
`include "sdms_defs.vh"
module sdms_seq_asserts
#(
	parameter TABLE_BITS  = 10,
	parameter PERIOD_BITS = 20,
	parameter CUR_BITS    = 5
)
(
	// Clock and reset
	input wire                       clk_sys,
	input wire                       sys_rst,
	// Pins and settings
	input wire                       step_in,
	input wire                       dir_in,
	input wire                       double_edge,
	input wire                       interp_en,
	input wire [`SDMS_RES_BITS-1:0]  resolution,
	input wire [CUR_BITS-1:0]        run_current_scale,
	input wire [CUR_BITS-1:0]        hold_current_scale,
	// Design outputs
	input wire [TABLE_BITS-1:0]      mscnt_r,
	input wire                       standstill_r,
	input wire [CUR_BITS-1:0]        current_scale_r,
	input wire                       microstep_r
);
	localparam int SET_AT = 2**PERIOD_BITS + 6;
	localparam int CLR_TO = 2**PERIOD_BITS - 4;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	reg                    step_q_r;
	reg [PERIOD_BITS+1:0]  idle_r;
	wire                   act = double_edge ? (step_in ^ step_q_r) : (step_in & ~step_q_r);
	wire [TABLE_BITS-1:0]  width = TABLE_BITS'(1) << resolution;
	// Cycles since last active pin edge, stops once the top bit sets
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			step_q_r <= 1'b0;
			idle_r   <= {1'b1, {(PERIOD_BITS+1){1'b0}}};
		end
		else
		begin
			step_q_r <= step_in;
			if (act)
				idle_r <= '0;
			else if (!idle_r[PERIOD_BITS+1])
				idle_r <= idle_r + 1'b1;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	scale_hold_a: assert property
		(!$past(sys_rst) && standstill_r |-> current_scale_r == $past(hold_current_scale))
		else $error("hold scale not selected in standstill");
	scale_run_a: assert property
		(!$past(sys_rst) && !standstill_r |-> current_scale_r == $past(run_current_scale))
		else $error("run scale not selected while moving");
	change_flag_a: assert property
		($changed(mscnt_r) |-> microstep_r)
		else $error("counter moved without microstep flag");
	flag_only_a: assert property
		(microstep_r |-> $changed(mscnt_r))
		else $error("microstep flag without counter move");
	step_width_a: assert property
		(!interp_en && !$past(interp_en) && resolution <= 4'h8 && $stable(resolution)
		&& resolution == $past(resolution, 2) && resolution == $past(resolution, 3)
		&& $past(dir_in, 3) == $past(dir_in, 8) && $changed(mscnt_r)
		|-> mscnt_r == ($past(dir_in, 5) ? $past(mscnt_r) - width : $past(mscnt_r) + width))
		else $error("counter moved by wrong amount");
	full_pos_a: assert property
		(resolution == 4'h8 && $past(resolution) == 4'h8 && $past(resolution, 2) == 4'h8
		&& $past(resolution, 3) == 4'h8 && !interp_en && !$past(interp_en)
		|-> mscnt_r[7:0] == 8'h80)
		else $error("fullstep position off grid");
	stst_set_a: assert property
		(idle_r >= SET_AT && !idle_r[PERIOD_BITS+1] |-> standstill_r)
		else $error("standstill missing after long idle");
	stst_clr_a: assert property
		(idle_r >= 6 && idle_r <= CLR_TO |-> !standstill_r)
		else $error("standstill not cleared by step");
	step_lat_a: assert property
		(act && !interp_en |-> ##1 $stable(mscnt_r)[*3] ##[1:2] $changed(mscnt_r))
		else $error("step edge not applied after sync delay");
	// Main scenarios reached
	cover property (standstill_r ##1 !standstill_r);
	cover property (resolution == 4'h8 && microstep_r);
	cover property (interp_en && microstep_r);
endmodule

bind sdms_sequencer sdms_seq_asserts #(
	.TABLE_BITS(TABLE_BITS), .PERIOD_BITS(PERIOD_BITS), .CUR_BITS(CUR_BITS)
) u_chk (.clk_sys, .sys_rst, .step_in, .dir_in, .double_edge, .interp_en, .resolution,
	.run_current_scale, .hold_current_scale, .mscnt_r, .standstill_r, .current_scale_r,
	.microstep_r);

//--- bench/sdms_ctrl_model.sv
// Purpose: motion controller issuing step and direction levels
// Assumes: called just after a rising clock edge
// Notes:   direction settles well before and after each step edge
`timescale 1ns/100ps
module sdms_ctrl_model
(
	// Clock
	input wire    clk_sys,
	// Pins toward the driver
	output logic  step_in,
	output logic  dir_in
);
	// Idle levels at time zero
	initial
	begin
		step_in = 1'b0;
		dir_in  = 1'b0;
	end
	// levels held whole clocks, step high for hi clocks then low for lo clocks
	task automatic pulse(input logic d, input int hi, input int lo);
		dir_in <= d;
		repeat (8) @(posedge clk_sys);
		step_in <= 1'b1;
		repeat (hi) @(posedge clk_sys);
		step_in <= 1'b0;
		repeat (lo) @(posedge clk_sys);
	endtask
endmodule

//--- bench/sdms_sequencer_test.sv
// Purpose: self-checking bench for the microstep sequencer
// Assumes: short period counter so standstill comes after 1023 clocks
// Notes:   expected positions kept in exp_pos
`timescale 1ns/100ps
`include "sdms_defs.vh"
`define SDMS_CHK(got, want) \
	begin num_checks++; if ((got) !== (want)) begin num_errors++; \
	$display("BAD t=%0t got=%h want=%h", $time, got, want); end end
module sdms_sequencer_test;
	logic        clk_sys, sys_rst, step_in, dir_in, double_edge, interp_en;
	logic [3:0]  resolution;
	logic [4:0]  run_current_scale, hold_current_scale, current_scale_r;
	logic [9:0]  mscnt_r, exp_pos;
	logic        standstill_r, microstep_r;
	int          num_errors, num_checks;
	sdms_sequencer #(.PERIOD_BITS(10)) dut (.clk_sys, .sys_rst, .step_in, .dir_in,
		.double_edge, .interp_en, .resolution, .run_current_scale, .hold_current_scale,
		.mscnt_r, .standstill_r, .current_scale_r, .microstep_r);
	sdms_ctrl_model u_ctrl (.clk_sys, .step_in, .dir_in);
	// 50 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Every resolution code coarsening in turn, then fullstep down past zero
	task automatic t_res_walk;
		logic [9:0] w;
		for (int k = 0; k <= 8; k++)
		begin
			w = 10'h1 << k;
			resolution <= k[3:0];
			cyc(4);
			exp_pos = (exp_pos & ~(w - 10'h1)) | (w >> 1);
			`SDMS_CHK(mscnt_r, exp_pos)
			u_ctrl.pulse(1'b0, 3, 3);
			cyc(6);
			exp_pos = exp_pos + w;
			`SDMS_CHK(mscnt_r, exp_pos)
		end
		// codes above 8 act as fullstep
		resolution <= 4'hf;
		for (int k = 0; k < 5; k++)
		begin
			u_ctrl.pulse(1'b1, 3, 3);
			cyc(6);
			exp_pos = exp_pos - 10'h100;
			`SDMS_CHK(mscnt_r, exp_pos)
			`SDMS_CHK(mscnt_r[7:0], 8'h80)
		end
		$display("t_res_walk done");
	endtask
	// Both edges active only with double edge set
	task automatic t_dedge;
		resolution <= 4'h0;
		double_edge <= 1'b1;
		u_ctrl.pulse(1'b0, 4, 4);
		cyc(6);
		exp_pos = exp_pos + 10'h2;
		`SDMS_CHK(mscnt_r, exp_pos)
		u_ctrl.pulse(1'b1, 4, 4);
		cyc(6);
		exp_pos = exp_pos - 10'h2;
		`SDMS_CHK(mscnt_r, exp_pos)
		double_edge <= 1'b0;
		u_ctrl.pulse(1'b0, 4, 4);
		cyc(6);
		exp_pos = exp_pos + 10'h1;
		`SDMS_CHK(mscnt_r, exp_pos)
		$display("t_dedge done");
	endtask
	// Long idle raises standstill and hold scale, next step clears both
	task automatic t_standstill;
		`SDMS_CHK(standstill_r, 1'b0)
		cyc(1100);
		`SDMS_CHK(standstill_r, 1'b1)
		`SDMS_CHK(current_scale_r, hold_current_scale)
		u_ctrl.pulse(1'b0, 3, 3);
		cyc(2);
		exp_pos = exp_pos + 10'h1;
		`SDMS_CHK(standstill_r, 1'b0)
		`SDMS_CHK(current_scale_r, run_current_scale)
		`SDMS_CHK(mscnt_r, exp_pos)
		$display("t_standstill done");
	endtask
	// Sixteen-entry steps spread over time, then a sudden faster rate
	task automatic t_interp;
		logic [9:0] d;
		resolution <= 4'h4;
		cyc(4);
		exp_pos = (exp_pos & ~10'hf) | 10'h8;
		`SDMS_CHK(mscnt_r, exp_pos)
		interp_en <= 1'b1;
		cyc(860);
		u_ctrl.pulse(1'b0, 2, 2);
		cyc(6);
		d = mscnt_r - exp_pos;
		`SDMS_CHK(d > 10'h0 && d < 10'h10, 1'b1)
		cyc(80);
		exp_pos = exp_pos + 10'h10;
		`SDMS_CHK(mscnt_r, exp_pos)
		u_ctrl.pulse(1'b0, 2, 2);
		u_ctrl.pulse(1'b0, 2, 2);
		cyc(60);
		exp_pos = exp_pos + 10'h20;
		`SDMS_CHK(mscnt_r, exp_pos)
		interp_en <= 1'b0;
		$display("t_interp done");
	endtask
	task automatic complete_run;
		$display("checks=%0d mismatches=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Watchdog well beyond the expected 2564 clocks
	initial
	begin
		cyc(12000);
		num_errors++;
		$display("BAD t=%0t got=%h want=%h", $time, 1'b0, 1'b1);
		complete_run;
	end
	// Main sequence
	initial
	begin
		sys_rst = 1'b1;
		double_edge = 1'b0;
		interp_en = 1'b0;
		resolution = 4'h0;
		run_current_scale = 5'h1c;
		hold_current_scale = 5'h06;
		num_errors = 0;
		num_checks = 0;
		exp_pos = 10'h000;
		cyc(16);
		sys_rst <= 1'b0;
		cyc(4);
		`SDMS_CHK(mscnt_r, 10'h000)
		t_res_walk;
		t_dedge;
		t_standstill;
		t_interp;
		complete_run;
	end
endmodule
